// [pkg/xbar_pkg.sv]
// Constants shared by the priority crossbar and its helpers
package xbar_pkg;

	// Pin and signal counts
	localparam int NUM_PORTS = 4;
	localparam int PORT_W    = 8;
	localparam int NUM_PINS  = NUM_PORTS * PORT_W;
	localparam int NUM_SIGS  = 28;
	localparam int SIG_IDX_W = 5;
	localparam int PIN_IDX_W = 6;
	localparam int SYNC_STAGES = 2;

	// Special function register addresses
	localparam logic [7:0] ADDR_PORT0     = 8'h80;
	localparam logic [7:0] ADDR_PORT1     = 8'h90;
	localparam logic [7:0] ADDR_PORT2     = 8'hA0;
	localparam logic [7:0] ADDR_PORT3     = 8'hB0;
	localparam logic [7:0] ADDR_XBAR_CFG0 = 8'hE1;
	localparam logic [7:0] ADDR_XBAR_CFG1 = 8'hE2;
	localparam logic [7:0] ADDR_XBAR_CFG2 = 8'hE3;

	// Values after reset
	localparam logic [7:0] RST_XBAR_CFG  = 8'h00;
	localparam logic [7:0] RST_PORT_DATA = 8'hFF;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// Field positions, first configuration register
	localparam int CFG0_TWO_WIRE  = 0;
	localparam int CFG0_SPI       = 1;
	localparam int CFG0_SERIAL0   = 2;
	localparam int CFG0_CEX_LO    = 3;
	localparam int CFG0_CEX_HI    = 5;
	localparam int CFG0_ECI       = 6;
	localparam int CFG0_CP0       = 7;
	// Field positions, second configuration register
	localparam int CFG1_CP1       = 0;
	localparam int CFG1_T0        = 1;
	localparam int CFG1_EXT_IRQ0_PIN      = 2;
	localparam int CFG1_T1        = 3;
	localparam int CFG1_EXT_IRQ1_PIN      = 4;
	localparam int CFG1_T2        = 5;
	localparam int CFG1_TIMER2_EXT_TRIGGER      = 6;
	localparam int CFG1_OUTPUT_PIN_A    = 7;
	// Field positions, third configuration register
	localparam int CFG2_CNVST     = 0;
	localparam int CFG2_SERIAL1   = 2;
	localparam int CFG2_T4        = 3;
	localparam int CFG2_TIMER4_EXT_TRIGGER      = 4;
	localparam int CFG2_GLOBAL_EN = 6;

	// Peripheral signal slots in descending priority
	localparam int SIG_SER0_TX  = 0;
	localparam int SIG_SER0_RX  = 1;
	localparam int SIG_SPI_SCK  = 2;
	localparam int SIG_SPI_MISO = 3;
	localparam int SIG_SPI_MOSI = 4;
	localparam int SIG_SPI_NSS  = 5;
	localparam int SIG_TW_SDA   = 6;
	localparam int SIG_TW_SCL   = 7;
	localparam int SIG_SER1_TX  = 8;
	localparam int SIG_SER1_RX  = 9;
	localparam int SIG_COUNTER_ARRAY_OUT0     = 10;
	localparam int NUM_CEX      = 5;
	localparam int SIG_ECI      = 15;
	localparam int SIG_CP0      = 16;
	localparam int SIG_CP1      = 17;
	localparam int SIG_T0       = 18;
	localparam int SIG_EXT_IRQ0_PIN     = 19;
	localparam int SIG_T1       = 20;
	localparam int SIG_EXT_IRQ1_PIN     = 21;
	localparam int SIG_T2       = 22;
	localparam int SIG_TIMER2_EXT_TRIGGER     = 23;
	localparam int SIG_T4       = 24;
	localparam int SIG_TIMER4_EXT_TRIGGER     = 25;
	localparam int SIG_OUTPUT_PIN_A   = 26;
	localparam int SIG_CNVST    = 27;

	// Slots that are inputs only: their pin driver stays off
	localparam logic [NUM_SIGS-1:0] SIG_INPUT_ONLY =
		(28'h1 << SIG_SER0_RX) | (28'h1 << SIG_SER1_RX) | (28'h1 << SIG_ECI) |
		(28'h1 << SIG_T0) | (28'h1 << SIG_EXT_IRQ0_PIN) | (28'h1 << SIG_T1) |
		(28'h1 << SIG_EXT_IRQ1_PIN) | (28'h1 << SIG_T2) | (28'h1 << SIG_TIMER2_EXT_TRIGGER) |
		(28'h1 << SIG_T4) | (28'h1 << SIG_TIMER4_EXT_TRIGGER) | (28'h1 << SIG_CNVST);

endpackage : xbar_pkg

// [design/pin_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce) begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : pin_sync

// [design/priority_crossbar_port_mux.sv]
// Priority crossbar handing port pins to peripherals, with port data registers
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Pins are handed out upward from port 0 pin 0, at most to port 3 pin 3 with all 28 slots enabled.
// - Peripheral signals are placed in fixed priority, serial port 0 first, conversion last.
// - Only peripherals whose enable bits are set consume and reach pins.
// - First config register: bit0 two-wire, bit1 SPI, bit2 serial port 0.
// - A serial peripheral always gets all its signals together.
// - The mapping is a pure function of the enable bits.
// - Unallocated pins act as general-purpose I/O through the port data register.
// - Port data registers accept byte writes and single-bit writes.
// - An allocated pin is driven by its peripheral, not the port latch.
// - Port data writes never change an allocated pin's level.
// - Ordinary port reads return the sampled pin levels.
// - The read phase of read-modify-write returns the port latch instead.
// - Bit 6 of the third config register turns the crossbar on.
// - With the crossbar off, every port output driver is disabled.
// - Pins carrying peripheral inputs have their output driver disabled.
// - Memory interface drives port 3 data and port 2 address; port 1 address only when not multiplexed.
module priority_crossbar_port_mux
	import xbar_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Special function register bus
	input  wire logic [7:0]           sfr_addr,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_bit_wr,
	input  wire logic [2:0]           sfr_bit_sel,
	input  wire logic [7:0]           sfr_wdata,
	input  wire logic                 sfr_rd,
	input  wire logic                 sfr_rmw,
	output logic      [7:0]           sfr_rdata,
	// Peripheral side
	input  wire logic [NUM_SIGS-1:0]  periph_out,
	input  wire logic [NUM_SIGS-1:0]  periph_oe,
	output logic      [NUM_SIGS-1:0]  periph_in,
	// External memory interface on ports 1 to 3
	input  wire logic                 emif_active,
	input  wire logic                 emif_muxed,
	input  wire logic                 emif_addr_phase,
	input  wire logic [15:0]          emif_addr,
	input  wire logic [7:0]           emif_dout,
	input  wire logic                 emif_data_oe,
	// Port pins
	input  wire logic [NUM_PINS-1:0]  pin_in,
	output logic      [NUM_PINS-1:0]  pin_out,
	output logic      [NUM_PINS-1:0]  pin_oe,
	output logic                      crossbar_global_enable
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0]           crossbar_config_0_ff;
	logic [7:0]           crossbar_config_1_ff;
	logic [7:0]           crossbar_config_2_ff;
	logic [7:0]           port_data_ff [NUM_PORTS];
	logic [7:0]           nxt_port_data [NUM_PORTS];
	logic [7:0]           sfr_rdata_ff;
	logic [7:0]           nxt_sfr_rdata;
	logic [NUM_PINS-1:0]  pin_level;
	logic [NUM_PINS-1:0]  latch_flat;
	logic [NUM_SIGS-1:0]  sig_en;
	logic [PIN_IDX_W-1:0] sig_pos [NUM_SIGS];
	logic [NUM_PINS-1:0]  pin_alloc;
	logic [SIG_IDX_W-1:0] pin_sig [NUM_PINS];
	logic [NUM_PINS-1:0]  xbar_out;
	logic [NUM_PINS-1:0]  xbar_oe;
	logic [2:0]           cex_count;

	////////////////////////////////////////////////////////////////////////////
	// Pin levels are asynchronous to the core clock
	pin_sync #(
		.WIDTH (NUM_PINS)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.async_in (pin_in),
		.sync_out (pin_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	wire wr_cfg0 = sfr_wr && (sfr_addr == ADDR_XBAR_CFG0);
	wire wr_cfg1 = sfr_wr && (sfr_addr == ADDR_XBAR_CFG1);
	wire wr_cfg2 = sfr_wr && (sfr_addr == ADDR_XBAR_CFG2);
	wire [NUM_PORTS-1:0] hit_port;
	assign hit_port[0] = (sfr_addr == ADDR_PORT0);
	assign hit_port[1] = (sfr_addr == ADDR_PORT1);
	assign hit_port[2] = (sfr_addr == ADDR_PORT2);
	assign hit_port[3] = (sfr_addr == ADDR_PORT3);

	// config takes effect
	// Mapping is decoded from the config flops, so a write shows next cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crossbar_config_0_ff <= RST_XBAR_CFG;
			crossbar_config_1_ff <= RST_XBAR_CFG;
			crossbar_config_2_ff <= RST_XBAR_CFG;
		end else if (ce) begin
			if (wr_cfg0)
				crossbar_config_0_ff <= sfr_wdata;
			if (wr_cfg1)
				crossbar_config_1_ff <= sfr_wdata;
			if (wr_cfg2)
				crossbar_config_2_ff <= sfr_wdata;
		end
	end

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			nxt_port_data[p] = port_data_ff[p];
			if (hit_port[p] && sfr_wr)
				nxt_port_data[p] = sfr_wdata;
			else if (hit_port[p] && sfr_bit_wr)
				nxt_port_data[p][sfr_bit_sel] = sfr_wdata[0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < NUM_PORTS; p++)
				port_data_ff[p] <= RST_PORT_DATA;
		end else if (ce) begin
			for (int p = 0; p < NUM_PORTS; p++)
				port_data_ff[p] <= nxt_port_data[p];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read: pin levels, port latch or config registers
	always_comb begin
		nxt_sfr_rdata = sfr_rdata_ff;
		if (sfr_rd) begin
			nxt_sfr_rdata = RD_UNMAPPED;
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (hit_port[p])
					nxt_sfr_rdata = sfr_rmw ? port_data_ff[p]
					                        : pin_level[p*PORT_W +: PORT_W];
			end
			if (sfr_addr == ADDR_XBAR_CFG0)
				nxt_sfr_rdata = crossbar_config_0_ff;
			if (sfr_addr == ADDR_XBAR_CFG1)
				nxt_sfr_rdata = crossbar_config_1_ff;
			if (sfr_addr == ADDR_XBAR_CFG2)
				nxt_sfr_rdata = crossbar_config_2_ff;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			sfr_rdata_ff <= RD_UNMAPPED;
		else if (ce)
			sfr_rdata_ff <= nxt_sfr_rdata;
	end

	assign sfr_rdata = sfr_rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// global enable bit
	assign crossbar_global_enable = crossbar_config_2_ff[CFG2_GLOBAL_EN];

	// Field values above five still select all five counter outputs
	wire [2:0] cex_field = crossbar_config_0_ff[CFG0_CEX_HI:CFG0_CEX_LO];
	assign cex_count = (cex_field > 3'(NUM_CEX)) ? 3'(NUM_CEX) : cex_field;

	always_comb begin
		sig_en = '0;
		sig_en[SIG_SER0_TX]  = crossbar_config_0_ff[CFG0_SERIAL0];
		sig_en[SIG_SER0_RX]  = crossbar_config_0_ff[CFG0_SERIAL0];
		sig_en[SIG_SPI_SCK]  = crossbar_config_0_ff[CFG0_SPI];
		sig_en[SIG_SPI_MISO] = crossbar_config_0_ff[CFG0_SPI];
		sig_en[SIG_SPI_MOSI] = crossbar_config_0_ff[CFG0_SPI];
		sig_en[SIG_SPI_NSS]  = crossbar_config_0_ff[CFG0_SPI];
		sig_en[SIG_TW_SDA]   = crossbar_config_0_ff[CFG0_TWO_WIRE];
		sig_en[SIG_TW_SCL]   = crossbar_config_0_ff[CFG0_TWO_WIRE];
		sig_en[SIG_SER1_TX]  = crossbar_config_2_ff[CFG2_SERIAL1];
		sig_en[SIG_SER1_RX]  = crossbar_config_2_ff[CFG2_SERIAL1];
		for (int c = 0; c < NUM_CEX; c++)
			sig_en[SIG_COUNTER_ARRAY_OUT0 + c] = (3'(c) < cex_count);
		sig_en[SIG_ECI]    = crossbar_config_0_ff[CFG0_ECI];
		sig_en[SIG_CP0]    = crossbar_config_0_ff[CFG0_CP0];
		sig_en[SIG_CP1]    = crossbar_config_1_ff[CFG1_CP1];
		sig_en[SIG_T0]     = crossbar_config_1_ff[CFG1_T0];
		sig_en[SIG_EXT_IRQ0_PIN]   = crossbar_config_1_ff[CFG1_EXT_IRQ0_PIN];
		sig_en[SIG_T1]     = crossbar_config_1_ff[CFG1_T1];
		sig_en[SIG_EXT_IRQ1_PIN]   = crossbar_config_1_ff[CFG1_EXT_IRQ1_PIN];
		sig_en[SIG_T2]     = crossbar_config_1_ff[CFG1_T2];
		sig_en[SIG_TIMER2_EXT_TRIGGER]   = crossbar_config_1_ff[CFG1_TIMER2_EXT_TRIGGER];
		sig_en[SIG_T4]     = crossbar_config_2_ff[CFG2_T4];
		sig_en[SIG_TIMER4_EXT_TRIGGER]   = crossbar_config_2_ff[CFG2_TIMER4_EXT_TRIGGER];
		sig_en[SIG_OUTPUT_PIN_A] = crossbar_config_1_ff[CFG1_OUTPUT_PIN_A];
		sig_en[SIG_CNVST]  = crossbar_config_2_ff[CFG2_CNVST];
	end

	// deterministic mapping
	// Each enabled slot takes the next free pin; 28 slots never exceed 32 pins
	always_comb begin
		logic [PIN_IDX_W-1:0] cnt;
		cnt = '0;
		for (int s = 0; s < NUM_SIGS; s++) begin
			sig_pos[s] = cnt;
			if (sig_en[s])
				cnt = cnt + 6'd1;
		end
	end

	always_comb begin
		for (int j = 0; j < NUM_PINS; j++) begin
			pin_alloc[j] = 1'b0;
			pin_sig[j]   = '0;
			for (int s = 0; s < NUM_SIGS; s++) begin
				if (sig_en[s] && (sig_pos[s] == 6'(j))) begin
					pin_alloc[j] = 1'b1;
					pin_sig[j]   = 5'(s);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++)
			latch_flat[p*PORT_W +: PORT_W] = port_data_ff[p];
	end

	// input pins undriven
	// GPIO pins behave open-drain: a latched 1 releases the pin for input use
	always_comb begin
		for (int j = 0; j < NUM_PINS; j++) begin
			if (pin_alloc[j]) begin
				xbar_out[j] = periph_out[pin_sig[j]];
				xbar_oe[j]  = periph_oe[pin_sig[j]] && !SIG_INPUT_ONLY[pin_sig[j]];
			end else begin
				xbar_out[j] = latch_flat[j];
				xbar_oe[j]  = !latch_flat[j];
			end
		end
	end

	always_comb begin
		pin_out = xbar_out;
		pin_oe  = xbar_oe;
		if (emif_active) begin
			pin_out[3*PORT_W +: PORT_W] = (emif_muxed && emif_addr_phase) ?
			                              emif_addr[7:0] : emif_dout;
			pin_oe[3*PORT_W +: PORT_W]  = {PORT_W{emif_data_oe || emif_addr_phase}};
			pin_out[2*PORT_W +: PORT_W] = emif_muxed ? emif_addr[15:8] : emif_addr[7:0];
			pin_oe[2*PORT_W +: PORT_W]  = {PORT_W{1'b1}};
			if (!emif_muxed) begin
				pin_out[1*PORT_W +: PORT_W] = emif_addr[15:8];
				pin_oe[1*PORT_W +: PORT_W]  = {PORT_W{1'b1}};
			end
		end
		if (!crossbar_global_enable)
			pin_oe = '0;
	end

	always_comb begin
		for (int s = 0; s < NUM_SIGS; s++)
			periph_in[s] = (sig_en[s] && crossbar_global_enable) ?
			               pin_level[5'(sig_pos[s])] : 1'b1;
	end

endmodule : priority_crossbar_port_mux

// [dv/pin_pad_model.sv]
// Board model that resolves each port pin from the device driver and the board
`timescale 1ns/1ns
module pin_pad_model
	import xbar_pkg::*;
(
	input  wire logic [NUM_PINS-1:0] pin_out,
	input  wire logic [NUM_PINS-1:0] pin_oe,
	input  wire logic [NUM_PINS-1:0] ext_val,
	output logic      [NUM_PINS-1:0] pin_in
);
	// Undriven pins take the board value; the bench sets it all ones for a pull-up but randomises it in the mapping checks and from the pin-read check on
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : pin_pad_model

// [dv/xbar_checker.sv]
// Concurrent checks on the crossbar port mux ports
`timescale 1ns/1ns
module xbar_checker
	import xbar_pkg::*;
(
	input wire logic                core_clk,
	input wire logic                rst,
	input wire logic                ce,
	input wire logic [7:0]          sfr_addr,
	input wire logic                sfr_wr,
	input wire logic                sfr_bit_wr,
	input wire logic [2:0]          sfr_bit_sel,
	input wire logic [7:0]          sfr_wdata,
	input wire logic                sfr_rd,
	input wire logic                sfr_rmw,
	input wire logic [7:0]          sfr_rdata,
	input wire logic [NUM_SIGS-1:0] periph_out,
	input wire logic [NUM_SIGS-1:0] periph_oe,
	input wire logic [NUM_SIGS-1:0] periph_in,
	input wire logic                emif_active,
	input wire logic                emif_muxed,
	input wire logic [15:0]         emif_addr,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic                crossbar_global_enable
);
	logic [7:0] cfg0_ff, cfg1_ff, cfg2_ff, prev_ff;
	logic [1:0] still_ff;
	wire        wr_take   = ce && sfr_wr;
	wire [7:0]  port2     = pin_out[23:16];
	// Only serial port 0 mapped: its two pins known, everything else plain port
	wire        ser0_only = cfg0_ff == 8'h04 && cfg1_ff == 8'h00 && (cfg2_ff & 8'h1D) == 8'h00
		&& crossbar_global_enable && !emif_active;
	////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg0_ff <= 8'h00;
			cfg1_ff <= 8'h00;
			cfg2_ff <= 8'h00;
			prev_ff <= 8'h00;
			still_ff <= 2'h0;
		end else if (ce) begin
			if (wr_take && sfr_addr == ADDR_XBAR_CFG0) cfg0_ff <= sfr_wdata;
			if (wr_take && sfr_addr == ADDR_XBAR_CFG1) cfg1_ff <= sfr_wdata;
			if (wr_take && sfr_addr == ADDR_XBAR_CFG2) cfg2_ff <= sfr_wdata;
			prev_ff <= pin_in[7:0];
			// Reads only trusted once the synchroniser has seen a steady level
			still_ff <= (pin_in[7:0] != prev_ff) ? 2'h0 : (still_ff == 2'h3 ? 2'h3 : still_ff + 2'h1);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_port0_write;
		wr_take && sfr_addr == ADDR_PORT0;
	endsequence
	sequence s_rmw_read;
		ce && sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT0;
	endsequence
	a_off_quiet: assert property (!crossbar_global_enable |-> pin_oe == '0 && &periph_in)
		else $error("drivers active with crossbar off");
	a_enable_follows: assert property (wr_take && sfr_addr == ADDR_XBAR_CFG2
		|=> crossbar_global_enable == $past(sfr_wdata[6])) else $error("global enable wrong");
	a_ser0_pins: assert property (ser0_only |-> pin_out[0] == periph_out[SIG_SER0_TX]
		&& pin_oe[0] == periph_oe[SIG_SER0_TX] && !pin_oe[1]) else $error("serial pins wrong");
	a_gpio_byte: assert property (ser0_only && wr_take && sfr_addr == ADDR_PORT1 ##1 ser0_only
		|-> pin_out[15:8] == $past(sfr_wdata) && pin_oe[15:8] == ~$past(sfr_wdata))
		else $error("port pins do not follow latch");
	a_bit_write: assert property (ser0_only && ce && sfr_bit_wr && !sfr_wr
		&& sfr_addr == ADDR_PORT2 ##1 ser0_only |-> port2[$past(sfr_bit_sel)] == $past(sfr_wdata[0]))
		else $error("bit write lost");
	a_pin_read: assert property (ce && sfr_rd && !sfr_rmw && sfr_addr == ADDR_PORT0
		&& still_ff == 2'h3 |=> sfr_rdata == $past(prev_ff)) else $error("pin read wrong");
	a_rmw_latch: assert property (s_port0_write ##1 !(sfr_wr || sfr_bit_wr) ##1 s_rmw_read
		|=> sfr_rdata == $past(sfr_wdata, 3)) else $error("latch read wrong");
	a_emif_addr: assert property (crossbar_global_enable && emif_active && !emif_muxed
		|-> pin_out[23:8] == {emif_addr[7:0], emif_addr[15:8]} && pin_oe[23:8] == 16'hFFFF)
		else $error("memory address pins wrong");
endmodule : xbar_checker

// [dv/priority_crossbar_port_mux_bench.sv]
// Self-checking bench for the priority crossbar port mux
`timescale 1ns/1ns
module priority_crossbar_port_mux_bench
	import xbar_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, t8, c0, c1, c2;
	logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic [NUM_SIGS-1:0] periph_out = '0, periph_oe = '0, periph_in, en;
	logic emif_active = 1'b0, emif_muxed = 1'b0, emif_addr_phase = 1'b0, emif_data_oe = 1'b0;
	logic [15:0] emif_addr = 16'h0000;
	logic [7:0] emif_dout = 8'h00;
	logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, ext_val = '1, e_oe, e_out, lev;
	logic crossbar_global_enable;
	int n_errors = 0, check_count = 0;
	always #50 core_clk = ~core_clk;
	priority_crossbar_port_mux u_priority_crossbar_port_mux (.core_clk(core_clk), .rst(rst),
		.ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
		.sfr_rdata(sfr_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .emif_active(emif_active), .emif_muxed(emif_muxed),
		.emif_addr_phase(emif_addr_phase), .emif_addr(emif_addr), .emif_dout(emif_dout),
		.emif_data_oe(emif_data_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.crossbar_global_enable(crossbar_global_enable));
	pin_pad_model u_pin_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
		.pin_in(pin_in));
	////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic bwr(input logic [7:0] a, input logic [2:0] b, input logic v);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_bit_sel = b;
		sfr_wdata = {7'h00, v};
		sfr_bit_wr = 1'b1;
		@(negedge core_clk);
		sfr_bit_wr = 1'b0;
	endtask : bwr
	task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] v);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rmw = m;
		sfr_rd = 1'b1;
		@(negedge core_clk);
		sfr_rd = 1'b0;
		sfr_rmw = 1'b0;
		v = sfr_rdata;
	endtask : rd
	// Assignment registers go first, the global enable last
	task automatic cfg(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2);
		wr(ADDR_XBAR_CFG0, a0);
		wr(ADDR_XBAR_CFG1, a1);
		wr(ADDR_XBAR_CFG2, a2);
	endtask : cfg
	function automatic logic [NUM_SIGS-1:0] slot_en(input logic [7:0] a0, a1, a2);
		logic [NUM_SIGS-1:0] e;
		e = '0;
		e[1:0] = {2{a0[2]}};
		e[5:2] = {4{a0[1]}};
		e[7:6] = {2{a0[0]}};
		e[9:8] = {2{a2[2]}};
		// Counter-array field above five still gives five outputs
		for (int i = 0; i < NUM_CEX; i++) e[SIG_COUNTER_ARRAY_OUT0+i] = i < a0[5:3];
		e[16:15] = a0[7:6];
		e[23:17] = a1[6:0];
		e[25:24] = a2[4:3];
		e[26] = a1[7];
		e[27] = a2[0];
		return e;
	endfunction : slot_en
	task automatic map_check(input logic [7:0] a0, a1, a2);
		int k;
		en = slot_en(a0, a1, a2);
		k = 0;
		e_oe = '0;
		e_out = '1;
		for (int s = 0; s < NUM_SIGS; s++) begin
			if (en[s]) begin
				e_oe[k] = periph_oe[s] & ~SIG_INPUT_ONLY[s];
				e_out[k] = periph_out[s];
				k++;
			end
		end
		lev = (e_oe & e_out) | (~e_oe & ext_val);
		chk("pin_oe", e_oe, pin_oe);
		chk("pin_out", e_out & e_oe, pin_out & e_oe);
		k = 0;
		for (int s = 0; s < NUM_SIGS; s++) begin
			chk("periph_in", en[s] ? lev[k] : 1'b1, periph_in[s]);
			k += en[s];
		end
	endtask : map_check
	task automatic report_and_stop;
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h16E3));
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		rd(ADDR_XBAR_CFG0, 1'b0, d);
		chk("cfg0_reset", 8'h00, d);
		periph_oe = '1;
		cfg(8'h07, 8'hFF, 8'h00);
		chk("oe_off", 32'h0, pin_oe);
		for (int i = 0; i < 24; i++) begin
			c0 = i == 0 ? 8'h04 : (i == 1 ? 8'h02 : (i == 2 ? 8'hFF : 8'($urandom)));
			c1 = i == 2 ? 8'hFF : (i < 2 ? 8'h00 : 8'($urandom));
			c2 = 8'($urandom) | 8'h40;
			cfg(c0, c1, c2);
			periph_out = $urandom;
			periph_oe = $urandom;
			ext_val = $urandom;
			repeat (3) @(negedge core_clk);
			map_check(c0, c1, c2);
		end
		ext_val = '1;
		cfg(8'h04, 8'h00, 8'h40);
		periph_oe = '1;
		periph_out = $urandom;
		d = $urandom;
		d[0] = ~periph_out[SIG_SER0_TX];
		wr(ADDR_PORT0, d);
		rd(ADDR_PORT0, 1'b1, t8);
		chk("rmw_read", d, t8);
		chk("tx_pin", periph_out[SIG_SER0_TX], pin_out[0]);
		chk("gpio_oe", 6'(~d[7:2]), pin_oe[7:2]);
		chk("rx_oe", 1'b0, pin_oe[1]);
		ext_val = $urandom;
		repeat (3) @(negedge core_clk);
		rd(ADDR_PORT0, 1'b0, t8);
		chk("pin_read", {d[7:2] & ext_val[7:2], ext_val[1], periph_out[0]}, t8);
		wr(ADDR_PORT1, 8'h5A);
		t8 = $urandom;
		bwr(ADDR_PORT2, t8[2:0], 1'b0);
		rd(ADDR_PORT2, 1'b1, d);
		chk("bit_write", 8'hFF & ~(8'h01 << t8[2:0]), d);
		bwr(ADDR_XBAR_CFG0, 3'h0, 1'b1);
		rd(ADDR_XBAR_CFG0, 1'b0, d);
		chk("cfg0_rw", 8'h04, d);
		rd(8'h00, 1'b0, d);
		chk("unmapped", RD_UNMAPPED, d);
		emif_addr = $urandom;
		emif_dout = $urandom;
		emif_data_oe = 1'b1;
		emif_active = 1'b1;
		@(negedge core_clk);
		chk("emif_plain", {emif_dout, emif_addr[7:0], emif_addr[15:8]}, pin_out[31:8]);
		emif_muxed = 1'b1;
		emif_addr_phase = 1'b1;
		@(negedge core_clk);
		chk("emif_mux", {emif_addr[7:0], emif_addr[15:8]}, pin_out[31:16]);
		emif_active = 1'b0;
		// Clock enable low must freeze the config registers
		ce = 1'b0;
		wr(ADDR_XBAR_CFG2, 8'h00);
		ce = 1'b1;
		chk("ce_hold", 1'b1, crossbar_global_enable);
		wr(ADDR_XBAR_CFG2, 8'h00);
		chk("oe_off", 32'h0, pin_oe);
		report_and_stop();
	end
endmodule : priority_crossbar_port_mux_bench
bind priority_crossbar_port_mux xbar_checker u_xbar_checker (.core_clk(core_clk), .rst(rst),
	.ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
	.sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
	.sfr_rdata(sfr_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
	.periph_in(periph_in), .emif_active(emif_active), .emif_muxed(emif_muxed),
	.emif_addr(emif_addr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.crossbar_global_enable(crossbar_global_enable));
